// [logic/wto_pkg.sv]
// wto_pkg: constants and carrier types for the waveform time trim register block
// assumes a single 20 MHz core clock and an APB master with 32-bit data
//
// Notes on behaviour
// - The sample or samples holding the waveform's highest voltage, if it is positive, form the overdrive segment.
// - The overdrive trim is added to the overdrive segment duration during playback.
// - The overdrive trim acts only in open-loop mode and is ignored in closed-loop mode.
// - The overdrive trim is signed and scaled by the current sample_step_period in ms.
// - Every positive sample that is not overdrive is positive sustain.
// - Positive sustain changes by the signed positive trim times the sample_step_period.
// - Every negative sample that is not braking is negative sustain.
// - Negative sustain changes by the signed negative trim times the sample_step_period.
// - The sample or samples holding the most negative voltage, if it is negative, form the braking segment.
// - Braking changes by the signed brake trim times the sample_step_period.
// - The brake trim acts only in open-loop mode and is ignored in closed-loop mode.
// - The rated-voltage register drives the full-scale reference output.
package wto_pkg;

  // register indices; byte address is four times the index
  localparam logic [7:0]  IDX_OVERDRIVE  = 8'h1A;
  localparam logic [7:0]  IDX_POS_SUST   = 8'h1B;
  localparam logic [7:0]  IDX_NEG_SUST   = 8'h1C;
  localparam logic [7:0]  IDX_BRAKE      = 8'h1D;
  localparam logic [7:0]  IDX_FULL_SCALE = 8'h1F;
  localparam logic [7:0]  IDX_CONTROL    = 8'h40;
  localparam logic [7:0]  IDX_STATUS     = 8'h41;

  localparam logic [7:0]  TRIM_RESET       = 8'h00;
  localparam logic [7:0]  FULL_SCALE_RESET = 8'h3F;
  localparam logic [0:0]  CONTROL_RESET    = 1'h0;
  localparam int          CTRL_CLOSED_BIT  = 0;
  localparam int          DUR_W            = 16;
  localparam int          STEP_W_MAX       = 12;

  // ------------------------------------------------------------
  // carrier types
  // ------------------------------------------------------------
  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } wto_apb_req_type;

  typedef struct packed {
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
  } wto_apb_rsp_type;

  // one-hot segment class of a sample
  typedef enum logic [4:0] {
    SEG_NONE      = 5'b00001,
    SEG_OVERDRIVE = 5'b00010,
    SEG_POS_SUST  = 5'b00100,
    SEG_NEG_SUST  = 5'b01000,
    SEG_BRAKE     = 5'b10000
  } wto_seg_type;

  // scan=1: peak search pass; scan=0: playback pass
  typedef struct packed {
    logic                    valid;
    logic                    scan;
    logic                    first;
    logic signed [7:0]       volt;
    logic [DUR_W-1:0]        dur;
  } wto_smp_type;

  typedef struct packed {
    logic                    valid;
    wto_seg_type             seg;
    logic [DUR_W-1:0]        dur;
  } wto_out_type;

endpackage

// [logic/wto_time_trim_regs.sv]
// wto_time_trim_regs: APB register bank and segment duration trimming
// assumes synchronous inputs on core_clk and a master that runs a scan pass
// over a waveform before playing it back
//
// Design decision made here: register access over APB.
`timescale 1ns/1ps
`default_nettype none

module wto_time_trim_regs #(
  parameter int STEP_W = 8
) (
  input  wire logic                     core_clk,           // 20 MHz core clock
  input  wire logic                     reset,              // sync reset, active high
  input  wire wto_pkg::wto_apb_req_type apb_req,            // APB request
  output var  wto_pkg::wto_apb_rsp_type apb_rsp,            // APB response
  input  wire logic [STEP_W-1:0]        sample_step_period, // sample_step_period, ms
  input  wire wto_pkg::wto_smp_type     smp_in,             // waveform sample stream
  output var  wto_pkg::wto_out_type     smp_out,            // classified, trimmed sample
  output var  logic [7:0]               full_scale_ref,     // closed-loop full-scale ref
  output var  logic                     closed_loop         // loop mode in use
);
  import wto_pkg::*;

  if (STEP_W < 1 || STEP_W > STEP_W_MAX) begin : g_step_check
    $error("STEP_W out of range");
  end

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  typedef struct packed {
    wto_apb_rsp_type   rsp;
    logic [7:0]        overdrive_time_trim;
    logic [7:0]        pos_sustain_time_trim;
    logic [7:0]        neg_sustain_time_trim;
    logic [7:0]        brake_time_trim;
    logic [7:0]        full_scale_voltage_ref;
    logic              closed;
    logic signed [7:0] peak_max;
    logic signed [7:0] peak_min;
    wto_seg_type       prev_seg;
    wto_out_type       out;
  } wto_state_type;

  wto_state_type st_q;
  wto_state_type st_d;

  localparam int PROD_W = 8 + STEP_W + 1;
  localparam int SUM_W  = DUR_W + PROD_W + 1;

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  function automatic logic [7:0] reg_index(input logic [11:0] addr);
    reg_index = addr[9:2];
  endfunction

  function automatic logic reg_known(input logic [7:0] idx);
    reg_known = (idx == IDX_OVERDRIVE) || (idx == IDX_POS_SUST) || (idx == IDX_NEG_SUST)
             || (idx == IDX_BRAKE) || (idx == IDX_FULL_SCALE) || (idx == IDX_CONTROL)
             || (idx == IDX_STATUS);
  endfunction

  // signed trim times interval, added once per segment, clamped at both ends
  function automatic logic [DUR_W-1:0] trim_dur(input logic [DUR_W-1:0]  dur,
                                                input logic [7:0]        trim,
                                                input logic [STEP_W-1:0] step);
    logic signed [PROD_W-1:0] prod;
    logic signed [SUM_W-1:0]  sum;
    prod = PROD_W'($signed(trim) * $signed({1'b0, step}));
    sum  = SUM_W'($signed({1'b0, dur})) + SUM_W'(prod);
    if (sum < 0) begin
      trim_dur = '0;
    end else if (sum > SUM_W'({DUR_W{1'b1}})) begin
      trim_dur = {DUR_W{1'b1}};
    end else begin
      trim_dur = sum[DUR_W-1:0];
    end
  endfunction

  // max tested before min; a flat waveform reads as overdrive if positive, braking if negative
  function automatic wto_seg_type classify(input logic signed [7:0] v,
                                           input logic signed [7:0] vmax,
                                           input logic signed [7:0] vmin);
    if (v == vmax && v > 0) begin
      classify = SEG_OVERDRIVE;
    end else if (v == vmin && v < 0) begin
      classify = SEG_BRAKE;
    end else if (v > 0) begin
      classify = SEG_POS_SUST;
    end else if (v < 0) begin
      classify = SEG_NEG_SUST;
    end else begin
      classify = SEG_NONE;
    end
  endfunction

  // ------------------------------------------------------------
  // next state
  // ------------------------------------------------------------
  logic [7:0]   idx;
  logic         setup;
  logic         access;
  wto_seg_type  seg;
  logic [7:0]   trim;

  always_comb begin
    st_d   = st_q;
    idx    = reg_index(apb_req.paddr);
    setup  = apb_req.psel && !apb_req.penable;
    access = apb_req.psel && apb_req.penable && st_q.rsp.pready;

    // ------------------------------------------------------------
    // register access
    // ------------------------------------------------------------
    // response prepared in setup so it leaves a flop in the access phase
    st_d.rsp.pready = setup;
    if (setup) begin
      st_d.rsp.pslverr = !reg_known(idx) || (apb_req.paddr[1:0] != 2'h0)
                       || (apb_req.paddr[11:10] != 2'h0)
                       || (apb_req.pwrite && idx == IDX_STATUS);
      st_d.rsp.prdata  = 32'h0;
      if (!apb_req.pwrite) begin
        unique case (idx)
          IDX_OVERDRIVE:  st_d.rsp.prdata[7:0] = st_q.overdrive_time_trim;
          IDX_POS_SUST:   st_d.rsp.prdata[7:0] = st_q.pos_sustain_time_trim;
          IDX_NEG_SUST:   st_d.rsp.prdata[7:0] = st_q.neg_sustain_time_trim;
          IDX_BRAKE:      st_d.rsp.prdata[7:0] = st_q.brake_time_trim;
          IDX_FULL_SCALE: st_d.rsp.prdata[7:0] = st_q.full_scale_voltage_ref;
          IDX_CONTROL:    st_d.rsp.prdata[CTRL_CLOSED_BIT] = st_q.closed;
          IDX_STATUS:     st_d.rsp.prdata[15:0] = {st_q.peak_min, st_q.peak_max};
          default:        st_d.rsp.prdata = 32'h0;
        endcase
      end
    end else begin
      // cleared on every other cycle so a dropped transfer leaves no stale data
      st_d.rsp.pslverr = 1'b0;
      st_d.rsp.prdata  = 32'h0;
    end

    // write lands only at the completing edge; errored writes change nothing
    if (access && apb_req.pwrite && !st_q.rsp.pslverr) begin
      unique case (idx)
        IDX_OVERDRIVE:  st_d.overdrive_time_trim    = apb_req.pwdata[7:0];
        IDX_POS_SUST:   st_d.pos_sustain_time_trim  = apb_req.pwdata[7:0];
        IDX_NEG_SUST:   st_d.neg_sustain_time_trim  = apb_req.pwdata[7:0];
        IDX_BRAKE:      st_d.brake_time_trim        = apb_req.pwdata[7:0];
        IDX_FULL_SCALE: st_d.full_scale_voltage_ref = apb_req.pwdata[7:0];
        IDX_CONTROL:    st_d.closed                 = apb_req.pwdata[CTRL_CLOSED_BIT];
        default:        st_d.closed                 = st_q.closed;
      endcase
    end

    // ------------------------------------------------------------
    // sample path
    // ------------------------------------------------------------
    seg  = classify(smp_in.volt, st_q.peak_max, st_q.peak_min);
    trim = 8'h00;
    unique case (seg)
      SEG_OVERDRIVE: trim = st_q.closed ? 8'h00 : st_q.overdrive_time_trim;
      SEG_BRAKE:     trim = st_q.closed ? 8'h00 : st_q.brake_time_trim;
      SEG_POS_SUST:  trim = st_q.pos_sustain_time_trim;
      SEG_NEG_SUST:  trim = st_q.neg_sustain_time_trim;
      default:       trim = 8'h00;
    endcase

    st_d.out.valid = 1'b0;
    if (smp_in.valid && smp_in.scan) begin
      // peak search restarts on the first sample of a scan pass
      if (smp_in.first || smp_in.volt > st_q.peak_max) begin
        st_d.peak_max = smp_in.volt;
      end
      if (smp_in.first || smp_in.volt < st_q.peak_min) begin
        st_d.peak_min = smp_in.volt;
      end
    end else if (smp_in.valid) begin
      st_d.out.valid = 1'b1;
      st_d.out.seg   = seg;
      // a segment spans a run of samples; its trim is applied on the first one only
      if (smp_in.first || seg != st_q.prev_seg) begin
        st_d.out.dur = trim_dur(smp_in.dur, trim, sample_step_period);
      end else begin
        st_d.out.dur = smp_in.dur;
      end
      st_d.prev_seg = seg;
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      st_q.rsp                    <= '0;
      st_q.overdrive_time_trim    <= TRIM_RESET;
      st_q.pos_sustain_time_trim  <= TRIM_RESET;
      st_q.neg_sustain_time_trim  <= TRIM_RESET;
      st_q.brake_time_trim        <= TRIM_RESET;
      st_q.full_scale_voltage_ref <= FULL_SCALE_RESET;
      st_q.closed                 <= CONTROL_RESET[0];
      st_q.peak_max               <= 8'sh00;
      st_q.peak_min               <= 8'sh00;
      st_q.prev_seg               <= SEG_NONE;
      st_q.out                    <= '{valid: 1'b0, seg: SEG_NONE, dur: '0};
    end else begin
      st_q <= st_d;
    end
  end

  assign apb_rsp        = st_q.rsp;
  assign smp_out        = st_q.out;
  assign full_scale_ref = st_q.full_scale_voltage_ref;
  assign closed_loop    = st_q.closed;

  // ------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset);

  logic signed [7:0] pmax_h;
  logic signed [7:0] pmin_h;
  logic              new_run_h;
  assign pmax_h    = st_q.peak_max;
  assign pmin_h    = st_q.peak_min;
  assign new_run_h = smp_in.first || classify(smp_in.volt, pmax_h, pmin_h) != st_q.prev_seg;

  overdrive_class_a: assert property (smp_in.valid && !smp_in.scan && smp_in.volt == pmax_h
      && pmax_h > 0 |=> smp_out.valid && smp_out.seg == SEG_OVERDRIVE)
    else $error("peak sample not overdrive");

  brake_class_a: assert property (smp_in.valid && !smp_in.scan && smp_in.volt == pmin_h
      && pmin_h < 0 && smp_in.volt != pmax_h |=> smp_out.seg == SEG_BRAKE)
    else $error("lowest sample not braking");

  pos_class_a: assert property (smp_in.valid && !smp_in.scan && smp_in.volt > 0
      && smp_in.volt != pmax_h |=> smp_out.seg == SEG_POS_SUST)
    else $error("positive sample misclassified");

  neg_class_a: assert property (smp_in.valid && !smp_in.scan && smp_in.volt < 0
      && smp_in.volt != pmin_h && smp_in.volt != pmax_h |=> smp_out.seg == SEG_NEG_SUST)
    else $error("negative sample misclassified");

  closed_overdrive_a: assert property (closed_loop && smp_in.valid && !smp_in.scan
      && smp_in.volt == pmax_h && pmax_h > 0 |=> smp_out.dur == $past(smp_in.dur))
    else $error("overdrive trim used in closed loop");

  closed_brake_a: assert property (closed_loop && smp_in.valid && !smp_in.scan
      && smp_in.volt == pmin_h && pmin_h < 0 && smp_in.volt != pmax_h
      |=> smp_out.dur == $past(smp_in.dur))
    else $error("brake trim used in closed loop");

  pos_trim_a: assert property (!closed_loop && smp_in.valid && !smp_in.scan && new_run_h
      && smp_in.volt > 0 && smp_in.volt != pmax_h && $signed(st_q.pos_sustain_time_trim) > 0
      && sample_step_period != '0 && smp_in.dur < 16'h7000
      |=> smp_out.dur > $past(smp_in.dur))
    else $error("positive trim did not lengthen");

  neg_trim_a: assert property (smp_in.valid && !smp_in.scan && new_run_h && smp_in.volt < 0
      && smp_in.volt != pmin_h && smp_in.volt != pmax_h
      && $signed(st_q.neg_sustain_time_trim) < 0 && sample_step_period != '0
      && smp_in.dur != '0 |=> smp_out.dur < $past(smp_in.dur))
    else $error("negative trim did not shorten");

  clamp_zero_a: assert property (!closed_loop && smp_in.valid && !smp_in.scan && new_run_h
      && smp_in.volt == pmax_h && pmax_h > 0 && smp_in.dur == 16'h0001
      && st_q.overdrive_time_trim == 8'hFF && sample_step_period > 1
      |=> smp_out.dur == '0)
    else $error("negative result wrapped");

  brake_trim_a: assert property (!closed_loop && smp_in.valid && !smp_in.scan && new_run_h
      && smp_in.volt == pmin_h && pmin_h < 0 && smp_in.volt != pmax_h
      && st_q.brake_time_trim == 8'h01 && smp_in.dur < 16'h7000
      |=> smp_out.dur == $past(smp_in.dur) + DUR_W'($past(sample_step_period)))
    else $error("brake trim not applied");

  od_trim_a: assert property (!closed_loop && smp_in.valid && !smp_in.scan && new_run_h
      && smp_in.volt == pmax_h && pmax_h > 0 && $signed(st_q.overdrive_time_trim) > 0
      && sample_step_period != '0 && smp_in.dur < 16'h7000
      |=> smp_out.dur > $past(smp_in.dur))
    else $error("overdrive trim did not lengthen");

  // sustain trims stay live when the loop is closed
  closed_sust_a: assert property (closed_loop && smp_in.valid && !smp_in.scan && new_run_h
      && smp_in.volt > 0 && smp_in.volt != pmax_h && $signed(st_q.pos_sustain_time_trim) < 0
      && sample_step_period != '0 && smp_in.dur != '0
      |=> smp_out.dur < $past(smp_in.dur))
    else $error("sustain trim dropped in closed loop");

  run_hold_a: assert property (smp_in.valid && !smp_in.scan && !new_run_h
      |=> smp_out.dur == $past(smp_in.dur))
    else $error("trim applied twice in one segment");

  scan_silent_a: assert property (smp_in.valid && smp_in.scan |=> !smp_out.valid)
    else $error("scan sample produced output");

  out_hold_a: assert property (!smp_in.valid
      |=> !smp_out.valid && $stable(smp_out.seg) && $stable(smp_out.dur))
    else $error("idle output changed");

  // ------------------------------------------------------------
  // register bus checks
  // ------------------------------------------------------------
  full_scale_wr_a: assert property (access && apb_req.pwrite && !apb_rsp.pslverr
      && idx == IDX_FULL_SCALE |=> full_scale_ref == $past(apb_req.pwdata[7:0]))
    else $error("full scale write lost");

  apb_one_wait_a: assert property (setup |=> apb_rsp.pready ##1 !apb_rsp.pready)
    else $error("apb ready timing wrong");

  rsp_idle_a: assert property (!apb_rsp.pready |-> apb_rsp.prdata == 32'h0 && !apb_rsp.pslverr)
    else $error("response not zero outside access");

  ctrl_wr_a: assert property (access && apb_req.pwrite && !apb_rsp.pslverr
      && idx == IDX_CONTROL |=> closed_loop == $past(apb_req.pwdata[CTRL_CLOSED_BIT]))
    else $error("loop mode write lost");

  status_ro_a: assert property (access && apb_req.pwrite && idx == IDX_STATUS
      |-> apb_rsp.pslverr)
    else $error("status write not refused");

  read_upper_a: assert property (access && !apb_req.pwrite && idx != IDX_STATUS
      |-> apb_rsp.prdata[31:8] == 24'h0)
    else $error("upper read bits not zero");

  // a refused write must leave every register as it was
  err_hold_a: assert property (access && apb_req.pwrite && apb_rsp.pslverr
      |=> $stable(full_scale_ref) && $stable(closed_loop) && $stable(st_q.overdrive_time_trim)
      && $stable(st_q.pos_sustain_time_trim) && $stable(st_q.neg_sustain_time_trim)
      && $stable(st_q.brake_time_trim))
    else $error("refused write changed a register");

  // ------------------------------------------------------------
  // covers
  // ------------------------------------------------------------
  write_cov: cover property (access && apb_req.pwrite && idx == IDX_OVERDRIVE);
  read_cov: cover property (access && !apb_req.pwrite && idx == IDX_STATUS);
  brake_cov: cover property (smp_out.valid && smp_out.seg == SEG_BRAKE);
  clamp_cov: cover property (smp_out.valid && smp_out.seg == SEG_OVERDRIVE && smp_out.dur == '0);
  closed_cov: cover property (closed_loop && smp_out.valid && smp_out.seg == SEG_OVERDRIVE);

endmodule

`default_nettype wire

// [verif/testbench.sv]
// testbench: self-checking bench for the waveform time trim register block
// assumes wto_pkg and wto_time_trim_regs are compiled first; the bench drives APB and samples
`timescale 1ns/1ps
`default_nettype none

module testbench;
  import wto_pkg::*;

  localparam logic [7:0] STEP = 8'h03;

  logic              core_clk;
  logic              reset;
  wto_apb_req_type   apb_req;
  wto_apb_rsp_type   apb_rsp;
  logic [7:0]        sample_step_period;
  wto_smp_type       smp_in;
  wto_out_type       smp_out;
  logic [7:0]        full_scale_ref;
  logic              closed_loop;
  int                bad_count;
  int                num_checks;
  logic [31:0]       rd;
  logic              err;
  logic signed [7:0] wv [6] = '{8'sd40, 8'sd20, 8'sd20, 8'sd0, -8'sd20, -8'sd50};
  logic [15:0]       wd [6] = '{16'h000A, 16'h000A, 16'h000A, 16'h0007, 16'h000A, 16'h0064};
  logic [4:0]        sg [6] = '{SEG_OVERDRIVE, SEG_POS_SUST, SEG_POS_SUST, SEG_NONE,
                                SEG_NEG_SUST, SEG_BRAKE};

  wto_time_trim_regs #(.STEP_W(8)) dut_u (
    .core_clk           (core_clk),
    .reset              (reset),
    .apb_req            (apb_req),
    .apb_rsp            (apb_rsp),
    .sample_step_period (sample_step_period),
    .smp_in             (smp_in),
    .smp_out            (smp_out),
    .full_scale_ref     (full_scale_ref),
    .closed_loop        (closed_loop)
  );

  always #25 core_clk = ~core_clk;

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  function automatic logic [11:0] ba(input logic [7:0] idx);
    return {2'b00, idx, 2'b00};
  endfunction

  // reference trim: signed trim times the driven step, clamped to the 16-bit range
  function automatic logic [15:0] trimd(input logic [15:0] d, input logic [7:0] t);
    int r;
    r = int'(d) + int'($signed(t)) * int'(sample_step_period);
    if (r < 0) r = 0;
    if (r > 65535) r = 65535;
    return r[15:0];
  endfunction

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    num_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] %0t %s: got %h expected %h", $time, what, got, exp);
    end
  endtask

  // one APB transfer; request held until pready is sampled high at a rising edge
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wdat);
    int n;
    n = 0;
    @(posedge core_clk);
    apb_req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: wdat};
    @(posedge core_clk);
    apb_req.penable <= 1'b1;
    do begin
      @(posedge core_clk);
      n++;
    end while (apb_rsp.pready !== 1'b1);
    chk(n, 1, "wait states");
    rd = apb_rsp.prdata;
    err = apb_rsp.pslverr;
    apb_req.psel <= 1'b0;
    apb_req.penable <= 1'b0;
  endtask

  task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp, input logic eerr);
    apb(1'b0, a, 32'h0000_0000);
    chk(rd, exp, "read data");
    chk(err, eerr, "slave error");
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] wdat, input logic eerr);
    apb(1'b1, a, wdat);
    chk(err, eerr, "write error");
  endtask

  // one playback sample, judged in the cycle its result stands
  task automatic play(input logic signed [7:0] v, input logic [15:0] d, input logic f,
                      input logic [4:0] es, input logic [15:0] ed);
    @(posedge core_clk);
    smp_in <= '{valid: 1'b1, scan: 1'b0, first: f, volt: v, dur: d};
    @(posedge core_clk);
    smp_in.valid <= 1'b0;
    @(negedge core_clk);
    chk(smp_out.valid, 1'b1, "output strobe");
    chk(smp_out.seg, es, "segment class");
    chk(smp_out.dur, ed, "trimmed duration");
  endtask

  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task automatic t_reset;
    for (int i = 8'h1A; i <= 8'h1D; i++) begin
      rd_chk(ba(8'(i)), 32'h0000_0000, 1'b0);
    end
    rd_chk(ba(IDX_FULL_SCALE), 32'h0000_003F, 1'b0);
    chk(full_scale_ref, 8'h3F, "full scale port");
    chk(closed_loop, 1'b0, "loop mode");
  endtask

  task automatic t_regs;
    for (int i = 8'h1A; i <= 8'h1F; i++) begin
      if (i == 8'h1E) continue;
      wr(ba(8'(i)), 32'hFFFF_FF00 | 32'(i + 8'h80), 1'b0);
      rd_chk(ba(8'(i)), 32'(i + 8'h80), 1'b0);
    end
    chk(full_scale_ref, 8'h9F, "full scale port");
    rd_chk(ba(8'h1E), 32'h0000_0000, 1'b1);
    wr(ba(IDX_STATUS), 32'h0000_1234, 1'b1);
    wr(12'h069, 32'h0000_0055, 1'b1);
    rd_chk(ba(IDX_OVERDRIVE), 32'h0000_009A, 1'b0);
  endtask

  task automatic scan;
    for (int i = 0; i < 6; i++) begin
      @(posedge core_clk);
      smp_in <= '{valid: 1'b1, scan: 1'b1, first: i == 0, volt: wv[i], dur: wd[i]};
    end
    @(posedge core_clk);
    smp_in.valid <= 1'b0;
    @(negedge core_clk);
    chk(smp_out.valid, 1'b0, "scan output");
  endtask

  // second sample of the positive run continues the segment, so it keeps its duration
  // trims given are those in effect: zero for overdrive and braking in closed loop
  task automatic t_play(input logic [7:0] od, pos, neg, brk, input logic [15:0] d0);
    logic [7:0]  tr [6];
    logic [15:0] d;
    tr = '{od, pos, 8'h00, 8'h00, neg, brk};
    for (int i = 0; i < 6; i++) begin
      d = (i == 0) ? d0 : wd[i];
      play(wv[i], d, i == 0, sg[i], trimd(d, tr[i]));
    end
  endtask

  task automatic t_wave;
    wr(ba(IDX_OVERDRIVE), 32'h0000_0005, 1'b0);
    wr(ba(IDX_POS_SUST), 32'h0000_00FE, 1'b0);
    wr(ba(IDX_NEG_SUST), 32'h0000_0004, 1'b0);
    wr(ba(IDX_BRAKE), 32'h0000_0080, 1'b0);
    scan();
    rd_chk(ba(IDX_STATUS), 32'h0000_CE28, 1'b0);
    t_play(8'h05, 8'hFE, 8'h04, 8'h80, 16'h000A);
    wr(ba(IDX_CONTROL), 32'h0000_0001, 1'b0);
    rd_chk(ba(IDX_CONTROL), 32'h0000_0001, 1'b0);
    chk(closed_loop, 1'b1, "loop mode");
    t_play(8'h00, 8'hFE, 8'h04, 8'h00, 16'h000A);
    // back to open loop with a new step: clamp overdrive and negative sustain to zero, lengthen positive sustain and braking
    wr(ba(IDX_CONTROL), 32'h0000_0000, 1'b0);
    sample_step_period <= 8'h05;
    wr(ba(IDX_OVERDRIVE), 32'h0000_00FF, 1'b0);
    wr(ba(IDX_POS_SUST), 32'h0000_0003, 1'b0);
    wr(ba(IDX_NEG_SUST), 32'h0000_00FD, 1'b0);
    wr(ba(IDX_BRAKE), 32'h0000_0001, 1'b0);
    chk(closed_loop, 1'b0, "loop mode");
    t_play(8'hFF, 8'h03, 8'hFD, 8'h01, 16'h0001);
  endtask

  // ------------------------------------------------------------
  // sequence and verdict
  // ------------------------------------------------------------
  task automatic test_done;
    if (bad_count == 0 && num_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  initial begin
    core_clk = 1'b0;
    reset = 1'b1;
    apb_req = '0;
    smp_in = '0;
    sample_step_period = STEP;
    bad_count = 0;
    num_checks = 0;
    repeat (10) @(posedge core_clk);
    reset <= 1'b0;
    @(posedge core_clk);
    t_reset();
    t_regs();
    t_wave();
    test_done();
  end

  // whole run is under two hundred cycles; this bound only cuts a hang short
  initial begin
    repeat (4000) @(posedge core_clk);
    bad_count++;
    $display("[FAIL] %0t watchdog expired", $time);
    test_done();
  end

endmodule

`default_nettype wire
